// ---- common/cfrs_pkg.sv ----
package cfrs_pkg;

    // Bus geometry
    localparam int unsigned AW = 16;
    localparam int unsigned DW = 32;
    localparam int unsigned LW = 16;

    // Register indices as printed; byte address is four times the index
    localparam logic [AW-1:0] CTRL_IDX  = 16'h2800;
    localparam logic [AW-1:0] MSTAT_IDX = 16'h2802;
    localparam logic [AW-1:0] RSTAT_IDX = 16'h2804;
    localparam logic [AW-1:0] IEN_IDX   = 16'h2806;
    localparam logic [AW-1:0] FCTRL_IDX = 16'h2820;

    localparam logic [AW-1:0] CTRL_ADDR  = 16'hA000;
    localparam logic [AW-1:0] MSTAT_ADDR = 16'hA008;
    localparam logic [AW-1:0] RSTAT_ADDR = 16'hA010;
    localparam logic [AW-1:0] IEN_ADDR   = 16'hA018;
    localparam logic [AW-1:0] FCTRL_ADDR = 16'hA080;

    // Field positions
    localparam int unsigned CTRL_SWRST_BIT = 7;
    localparam int unsigned FCTRL_CLR_BIT  = 2;
    localparam int unsigned FCTRL_THR_LSB  = 4;
    localparam int unsigned FLAG_LSB       = 8;
    localparam int unsigned STS_LSB        = 12;
    localparam int unsigned TOP_LSB        = 14;
    localparam int unsigned NFLAG          = 3;

    // Flag order within bits 10..8
    localparam int unsigned FLG_EMPTY = 0;
    localparam int unsigned FLG_FULL  = 1;
    localparam int unsigned FLG_THR   = 2;

    // Fixed read values and reset values
    localparam logic [1:0]       TOP_VAL    = 2'h2;
    localparam logic [7:0]       LOW_VAL    = 8'h80;
    localparam logic [1:0]       THR_RST    = 2'h0;
    localparam logic [NFLAG-1:0] IEN_RST    = 3'h0;
    localparam logic [DW-1:0]    RDATA_RST  = 32'h0;

    // Occupancy limits in dwords
    localparam logic [LW:0] EMPTY_LIMIT = 17'h00002;
    localparam logic [LW:0] LEVEL_MIN3  = 17'h00003;

    // Trigger threshold selections
    localparam logic [1:0] THR_ANY     = 2'h0;
    localparam logic [1:0] THR_3DW     = 2'h1;
    localparam logic [1:0] THR_QUARTER = 2'h2;
    localparam logic [1:0] THR_HALF    = 2'h3;

endpackage

// ---- src/cfrs_flag.sv ----
module cfrs_flag
    import cfrs_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic clk_en,
    input  wire logic cond,
    input  wire logic hold,
    input  wire logic clr_wr,
    output logic      flag
);

    typedef struct packed {
        logic flag;
    } cfrs_flag_s;

    cfrs_flag_s st_q;
    cfrs_flag_s st_d;

    always_comb begin
        st_d = st_q;
        // Write-one clear only once the condition is gone or while the soft reset hold is set
        if (clr_wr && (!cond || hold)) begin
            st_d.flag = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (cond && !hold) begin
            st_d.flag = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign flag = st_q.flag;

endmodule

// ---- src/cfrs_thresh.sv ----
module cfrs_thresh
    import cfrs_pkg::*;
(
    input  wire logic [LW-1:0] cap_level,
    input  wire logic [7:0]    out_level,
    input  wire logic [LW-1:0] fifo_size,
    input  wire logic [1:0]    thr_sel,
    output logic               trig,
    output logic [1:0]         status
);

    logic [LW:0]   total;
    logic [LW+2:0] cap_x2;
    logic [LW+2:0] cap_x4;
    logic [LW+2:0] size_w;
    logic          half;
    logic          quarter;
    logic          three;

    always_comb begin
        total   = {1'b0, cap_level} + {{(LW-7){1'b0}}, out_level};
        cap_x2  = {2'b00, cap_level, 1'b0};
        cap_x4  = {1'b0, cap_level, 2'b00};
        size_w  = {3'b000, fifo_size};
        half    = (cap_x2 >= size_w);
        quarter = (cap_x4 >= size_w);
        three   = (total >= LEVEL_MIN3);
        // Occupancy status code
        if (total == '0) begin
            status = THR_ANY;
        end else if (half) begin
            status = THR_HALF;
        end else if (quarter) begin
            status = THR_QUARTER;
        end else if (three) begin
            status = THR_3DW;
        end else begin
            status = THR_ANY;
        end
        // Trigger comparison chosen by the threshold field
        case (thr_sel)
            THR_ANY:     trig = (total != '0);
            THR_3DW:     trig = three;
            THR_QUARTER: trig = quarter;
            THR_HALF:    trig = half;
            default:     trig = 1'b0;
        endcase
    end

endmodule

// ---- src/cfrs_top.sv ----
// Decided for this implementation: the APB register port and the register addresses.
module cfrs_top
    import cfrs_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          reset,
    input  wire logic          clk_en,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [DW-1:0] pwdata,
    input  wire logic [3:0]    pstrb,
    output logic               pready,
    output logic [DW-1:0]      prdata,
    output logic               pslverr,
    input  wire logic [LW-1:0] cap_level,
    input  wire logic [7:0]    out_level,
    input  wire logic [LW-1:0] fifo_size,
    input  wire logic          main_full,
    input  wire logic          in_full,
    output logic               cap_swrst,
    output logic               fifo_clr,
    output logic               irq
);

    typedef struct packed {
        logic             swrst;
        logic [1:0]       thr_sel;
        logic             fifo_clr;
        logic [NFLAG-1:0] ien;
        logic [DW-1:0]    rdata;
    } cfrs_top_s;

    cfrs_top_s st_q;
    cfrs_top_s st_d;

    logic             setup;
    logic             access;
    logic             wr_en;
    logic             hit;
    logic             hit_ctrl;
    logic             hit_mstat;
    logic             hit_rstat;
    logic             hit_ien;
    logic             hit_fctrl;
    logic [NFLAG-1:0] cond;
    logic [NFLAG-1:0] raw;
    logic [NFLAG-1:0] masked;
    logic [NFLAG-1:0] clr_vec;
    logic             trig;
    logic [1:0]       occ_sts;
    logic [15:0]      raw_word;
    logic [15:0]      mask_word;
    logic [DW-1:0]    rd_mux;

    // Address decode
    always_comb begin
        hit_ctrl  = (paddr == CTRL_ADDR);
        hit_mstat = (paddr == MSTAT_ADDR);
        hit_rstat = (paddr == RSTAT_ADDR);
        hit_ien   = (paddr == IEN_ADDR);
        hit_fctrl = (paddr == FCTRL_ADDR);
        hit       = hit_ctrl | hit_mstat | hit_rstat | hit_ien | hit_fctrl;
    end

    // Bus phases; the slave never stalls
    assign setup   = psel && !penable;
    assign access  = psel && penable;
    assign pready  = 1'b1;
    assign pslverr = access && !hit;
    assign wr_en   = access && pwrite && hit && clk_en;

    // Occupancy comparison
    cfrs_thresh u_thresh (
        .cap_level (cap_level),
        .out_level (out_level),
        .fifo_size (fifo_size),
        .thr_sel   (st_q.thr_sel),
        .trig      (trig),
        .status    (occ_sts)
    );

    // Conditions feeding the sticky flags; enables play no part here
    always_comb begin
        cond            = '0;
        cond[FLG_THR]   = trig;
        cond[FLG_FULL]  = main_full && in_full;
        cond[FLG_EMPTY] = ({{(LW-7){1'b0}}, out_level} < EMPTY_LIMIT);
    end

    // Write-one clears arrive through the masked status word only
    always_comb begin
        clr_vec = '0;
        if (wr_en && hit_mstat && pstrb[1]) begin
            clr_vec = pwdata[FLAG_LSB +: NFLAG];
        end
    end

    // One sticky flag per condition; FIFO clear is not an input here
    genvar gi;
    generate
        for (gi = 0; gi < NFLAG; gi++) begin : g_flag
            cfrs_flag u_flag (
                .sys_clk (sys_clk),
                .reset   (reset),
                .clk_en  (clk_en),
                .cond    (cond[gi]),
                .hold    (st_q.swrst),
                .clr_wr  (clr_vec[gi]),
                .flag    (raw[gi])
            );
        end
    endgenerate

    assign masked = raw & st_q.ien;

    // Read words
    always_comb begin
        raw_word                        = '0;
        raw_word[TOP_LSB +: 2]          = TOP_VAL;
        raw_word[STS_LSB +: 2]          = occ_sts;
        raw_word[FLAG_LSB +: NFLAG]     = raw;
        raw_word[7:0]                   = LOW_VAL;
        mask_word                       = raw_word;
        mask_word[FLAG_LSB +: NFLAG]    = masked;
    end

    always_comb begin
        rd_mux = '0;
        if (hit_ctrl) begin
            rd_mux[CTRL_SWRST_BIT] = st_q.swrst;
        end else if (hit_mstat) begin
            rd_mux[15:0] = mask_word;
        end else if (hit_rstat) begin
            rd_mux[15:0] = raw_word;
        end else if (hit_ien) begin
            rd_mux[FLAG_LSB +: NFLAG] = st_q.ien;
        end else if (hit_fctrl) begin
            rd_mux[FCTRL_THR_LSB +: 2] = st_q.thr_sel;
            rd_mux[FCTRL_CLR_BIT]      = st_q.fifo_clr;
        end else begin
            rd_mux = '0;
        end
    end

    // Register updates; raw status address has no writable bits
    always_comb begin
        st_d = st_q;
        if (setup && !pwrite) begin
            st_d.rdata = rd_mux;
        end
        if (wr_en && hit_ctrl && pstrb[0]) begin
            st_d.swrst = pwdata[CTRL_SWRST_BIT];
        end
        if (wr_en && hit_ien && pstrb[1]) begin
            st_d.ien = pwdata[FLAG_LSB +: NFLAG];
        end
        if (wr_en && hit_fctrl && pstrb[0]) begin
            st_d.thr_sel  = pwdata[FCTRL_THR_LSB +: 2];
            st_d.fifo_clr = pwdata[FCTRL_CLR_BIT];
        end
        if (wr_en && hit_rstat) begin
            st_d.ien = st_q.ien;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q.swrst    <= 1'b0;
            st_q.thr_sel  <= THR_RST;
            st_q.fifo_clr <= 1'b0;
            st_q.ien      <= IEN_RST;
            st_q.rdata    <= RDATA_RST;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign prdata    = st_q.rdata;
    assign cap_swrst = st_q.swrst;
    assign fifo_clr  = st_q.fifo_clr;
    assign irq       = |masked;

endmodule

// ---- test/cfrs_chk.sv ----
module cfrs_chk
    import cfrs_pkg::*;
(
    input wire logic          sys_clk,
    input wire logic          reset,
    input wire logic          clk_en,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [DW-1:0] pwdata,
    input wire logic [3:0]    pstrb,
    input wire logic          pready,
    input wire logic [DW-1:0] prdata,
    input wire logic          pslverr,
    input wire logic          cap_swrst,
    input wire logic          fifo_clr,
    input wire logic          irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire map_w = paddr inside {CTRL_ADDR, MSTAT_ADDR, RSTAT_ADDR, IEN_ADDR, FCTRL_ADDR};
    wire rd_w = psel && penable && !pwrite;
    wire wr_w = psel && penable && pwrite && clk_en && pstrb[0];
    ready_up_a: assert property (pready)
        else $error("pready low");
    err_unmap_a: assert property (psel && penable && !map_w |-> pslverr)
        else $error("pslverr missing");
    err_only_a: assert property (pslverr |-> psel && penable && !map_w)
        else $error("stray pslverr");
    raw_byte_a: assert property (rd_w && paddr == RSTAT_ADDR && $past(psel && !penable && clk_en && !reset)
        |-> prdata[15:14] == TOP_VAL && prdata[11] == 1'h0 && prdata[7:0] == LOW_VAL)
        else $error("raw fixed bits wrong");
    unmap_zero_a: assert property (rd_w && !map_w && $past(psel && !penable && clk_en && !reset) |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    clr_bit_a: assert property (wr_w && paddr == FCTRL_ADDR |=> fifo_clr == $past(pwdata[FCTRL_CLR_BIT]))
        else $error("fifo clear bit not stored");
    swrst_bit_a: assert property (wr_w && paddr == CTRL_ADDR |=> cap_swrst == $past(pwdata[CTRL_SWRST_BIT]))
        else $error("soft reset bit not stored");
    swrst_hold_a: assert property (!(wr_w && paddr == CTRL_ADDR) |=> $stable(cap_swrst))
        else $error("soft reset bit moved");
    irq_freeze_a: assert property (!clk_en |=> $stable(irq))
        else $error("irq moved while frozen");
endmodule

bind cfrs_top cfrs_chk chk_u (.sys_clk, .reset, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .cap_swrst, .fifo_clr, .irq);

// ---- test/tb_capture_fifo_raw_status.sv ----
module tb_capture_fifo_raw_status
    import cfrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic          sys_clk = 1'h0, reset = 1'h1, clk_en = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic          main_full = 1'h0, in_full = 1'h0, rd_e;
    logic [AW-1:0] paddr = 16'h0;
    logic [DW-1:0] pwdata = 32'h0, rd_v;
    logic [3:0]    pstrb = 4'hF;
    logic [LW-1:0] cap_level = 16'h0, fifo_size = 16'h10;
    logic [7:0]    out_level = 8'h0;
    logic [2:0]    ien, fl;
    logic [1:0]    sel;
    wire           pready, pslverr, cap_swrst, fifo_clr, irq;
    wire [DW-1:0]  prdata;
    int            error_cnt = 0, num_checks = 0, seed = 27261, i;

    cfrs_top dut_u (.sys_clk, .reset, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
        .prdata, .pslverr, .cap_level, .out_level, .fifo_size, .main_full, .in_full, .cap_swrst, .fifo_clr, .irq);

    initial forever #20 sys_clk = ~sys_clk;

    task automatic results;
        if (error_cnt == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer, read data and error taken at the ready edge
    task automatic bus(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge sys_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        @(posedge sys_clk);
        while (pready !== 1'h1) @(posedge sys_clk);
        rd_v = prdata;
        rd_e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic lvl(input logic [LW-1:0] c, input logic [7:0] o, input logic [LW-1:0] s, input logic mf, inf);
        @(posedge sys_clk);
        cap_level <= c;
        out_level <= o;
        fifo_size <= s;
        main_full <= mf;
        in_full <= inf;
        repeat (2) @(posedge sys_clk);
    endtask

    function automatic logic thr(int c, int o, int s, logic [1:0] t);
        case (t)
            2'h0: return c + o > 0;
            2'h1: return c + o >= 3;
            2'h2: return c * 4 >= s;
            default: return c * 2 >= s;
        endcase
    endfunction

    function automatic logic [DW-1:0] stat(logic [2:0] f);
        int c = int'(cap_level);
        int s = int'(fifo_size);
        logic [1:0] oc = thr(c, 0, s, 2'h3) ? 2'h3 : thr(c, 0, s, 2'h2) ? 2'h2 :
            thr(c, int'(out_level), s, 2'h1) ? 2'h1 : 2'h0;
        return {16'h0, TOP_VAL, oc, 1'h0, f, LOW_VAL};
    endfunction

    initial begin
        #200000;
        error_cnt++;
        results();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'h0;
        bus(1'h0, RSTAT_ADDR, 32'h0);
        chk(rd_v, stat(3'h1));
        lvl(16'h0, 8'h05, 16'h10, 1'h0, 1'h0);
        bus(1'h1, RSTAT_ADDR, 32'hFFFFFFFF);
        bus(1'h1, FCTRL_ADDR, 32'h4);
        bus(1'h0, RSTAT_ADDR, 32'h0);
        chk(rd_v, stat(3'h5));
        bus(1'h1, MSTAT_ADDR, 32'h500);
        bus(1'h0, RSTAT_ADDR, 32'h0);
        chk(rd_v, stat(3'h4));
        lvl(16'h0, 8'h05, 16'h10, 1'h1, 1'h1);
        bus(1'h1, CTRL_ADDR, 32'h80);
        bus(1'h1, MSTAT_ADDR, 32'h200);
        bus(1'h0, RSTAT_ADDR, 32'h0);
        chk(rd_v, stat(3'h4));
        bus(1'h1, CTRL_ADDR, 32'h0);
        bus(1'h0, RSTAT_ADDR, 32'h0);
        chk(rd_v, stat(3'h6));
        bus(1'h1, CTRL_ADDR, 32'h80);
        bus(1'h1, MSTAT_ADDR, 32'h200);
        bus(1'h0, RSTAT_ADDR, 32'h0);
        chk(rd_v, stat(3'h4));
        bus(1'h1, CTRL_ADDR, 32'h0);
        bus(1'h0, RSTAT_ADDR, 32'h0);
        chk(rd_v, stat(3'h6));
        lvl(16'h0, 8'h05, 16'h10, 1'h1, 1'h0);
        bus(1'h1, MSTAT_ADDR, 32'h200);
        bus(1'h0, RSTAT_ADDR, 32'h0);
        chk(rd_v, stat(3'h4));
        bus(1'h0, 16'hA004, 32'h0);
        chk({rd_v[30:0], rd_e}, 32'h1);
        clk_en <= 1'h0;
        bus(1'h1, CTRL_ADDR, 32'h80);
        clk_en <= 1'h1;
        chk(32'(cap_swrst), 32'h0);
        for (i = 0; i < 24; i++) begin
            sel = 2'($random(seed));
            ien = 3'($random(seed));
            lvl(16'($random(seed)) & 16'h00FF, 8'($random(seed)) & 8'h03, 16'($random(seed)) & 16'h00FF | 16'h1,
                1'($random(seed)), 1'($random(seed)));
            bus(1'h1, FCTRL_ADDR, {26'h0, sel, 4'h0} | 32'($random(seed)) & 32'h4);
            bus(1'h1, IEN_ADDR, {21'h0, ien, 8'h0});
            bus(1'h1, MSTAT_ADDR, 32'h700);
            fl = {thr(int'(cap_level), int'(out_level), int'(fifo_size), sel), main_full & in_full, out_level < 8'h2};
            bus(1'h0, RSTAT_ADDR, 32'h0);
            chk(rd_v, stat(fl));
            bus(1'h0, MSTAT_ADDR, 32'h0);
            chk(rd_v, stat(fl & ien));
            chk(32'(irq), 32'(|(fl & ien)));
        end
        results();
    end
endmodule
